// ===== verilog/ssup_params.svh
/*
  timing and reset constants for the supply reset supervisor.
  assumes a 20 MHz system clock; included by the core only.
*/
`ifndef SSUP_PARAMS_SVH
`define SSUP_PARAMS_SVH
`define SSUP_CLK_HZ 20000000
`define SSUP_DELAY_MS 50
`define SSUP_DELAY_MIN_MS 30
`define SSUP_DELAY_MAX_MS 75
`define SSUP_LATENCY_US 20
`define SSUP_MANUAL_MIN_US 15
`define SSUP_CNT_W 24
`define SSUP_SYNC_W 2
`define SSUP_SYNC_RST 2'h0
`define SSUP_CNT_RST 24'h000000
`define SSUP_CNT_ONE 24'h000001
`define SSUP_MIN_SLACK 24'h000003
`define SSUP_MS_PER_S 1000
`define SSUP_US_PER_S 1000000
`define SSUP_PIPE_MIN 4
`define SSUP_DELAY_MID_MS 100
`define SSUP_DELAY_LONG_MS 200
`endif

// ===== verilog/ssup_pkg.sv
/*
  types shared by the supply reset supervisor.
  assumes ssup_params.svh is on the include path.
*/
package ssup_pkg;
  // supervisor phases
  typedef enum logic [1:0] {
    SSUP_HOLD,
    SSUP_DELAY,
    SSUP_RUN
  } ssup_phase_t;
  // synchronised cause inputs
  typedef struct packed {
    logic low_sync;
    logic manual_sync;
  } ssup_cause_t;
  // state of the core controller and synchronisers
  typedef struct packed {
    logic [1:0] low_meta;
    logic [1:0] manual_meta;
    ssup_phase_t phase;
    logic [23:0] count;
    logic reset_out_n;
  } ssup_state_t;
endpackage

// ===== verilog/ssup_core.sv
/*
  digital core of a supply reset supervisor with manual reset: two-flop
  synchronisers for the undervoltage and manual causes, a three-phase
  controller (hold, delay, run), the release delay counter and the
  registered open-drain reset pin, plus the assertions that guard them.
  assumes comparator results arrive as logic levels asynchronous to the
  system clock, that the upper-level comparator is already clean, that the
  reset pin is open drain with an external pull-up, and that a power-on
  reset drives RST_N low until the internal bias is up.
*/
// Behaviour
// - assert reset at lower threshold
// - hold reset until upper threshold reached
// - upper threshold starts delay, reset held
// - release only above threshold after delay; the code does not recheck the upper level once the delay has started
// - delay is a build parameter
// - delay kept within tolerance bounds
// - only internal timer sets the delay
// - assert quickly, no programmed delay
// - manual request forces reset low
// - manual removal starts release delay
// - manual pulse of 15 us detected
// - reset asserted from power-up
// - output only sinks, never sources
`timescale 1ns/100ps
`include "ssup_params.svh"
// DELAY_MS picks the variant (50, 100 or 200 ms nominal) and is checked;
// DELAY_CYCLES is the count actually built and may be overridden to
// shorten simulation, in which case the tolerance checks scale with it.
// CLK_HZ only converts the nominal times into cycles; the counter width
// limits the longest delay that can be built at a given clock.
module ssup_core #(
  parameter int DELAY_MS = `SSUP_DELAY_MS,
  parameter int CLK_HZ = `SSUP_CLK_HZ,
  parameter int DELAY_CYCLES = (CLK_HZ / `SSUP_MS_PER_S) * DELAY_MS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic BELOW_LOWER,
  input wire logic ABOVE_UPPER,
  input wire logic MANUAL_REQ,
  output logic RESET_OUT_N_O,
  output logic RESET_OUT_N_OE
);
  // cycle budgets derived from the nominal times at this clock
  localparam int CYC_PER_US = CLK_HZ / `SSUP_US_PER_S; // cycles in one microsecond
  localparam int LATENCY_CYCLES = CYC_PER_US * `SSUP_LATENCY_US;
  localparam int MANUAL_CYCLES = CYC_PER_US * `SSUP_MANUAL_MIN_US;
  // tolerance scales with the delay actually built, so a shortened
  // simulation delay keeps the same proportion as the full-length part;
  // the products stay well inside an int for the longest variant
  localparam int MIN_CYCLES = DELAY_CYCLES * `SSUP_DELAY_MIN_MS / `SSUP_DELAY_MS;
  localparam int MAX_CYCLES = DELAY_CYCLES * `SSUP_DELAY_MAX_MS / `SSUP_DELAY_MS;

  // refuse delays the counter cannot hold or the nominal set does not allow;
  // checked at elaboration so a bad build never reaches simulation,
  // and a zero count would wrap the end value and make the pin wait through the whole 24-bit counter range
  if (DELAY_CYCLES < 1 || DELAY_CYCLES >= (1 << `SSUP_CNT_W)) begin : g_bad_cycles
    $error("release delay does not fit the counter");
  end
  if (DELAY_MS != `SSUP_DELAY_MS && DELAY_MS != `SSUP_DELAY_MID_MS
      && DELAY_MS != `SSUP_DELAY_LONG_MS) begin : g_bad_variant
    $error("release delay must be 50, 100 or 200 ms");
  end

  ssup_pkg::ssup_state_t st_ff; // registered state
  ssup_pkg::ssup_state_t nxt_st; // next state
  ssup_pkg::ssup_cause_t cause; // synchronised causes

  // second synchroniser stage is the only one read;
  // reading the first stage would let a metastable level leak into
  // the phase decode and split the controller's decisions
  function automatic logic hold_cause(input ssup_pkg::ssup_cause_t c);
    hold_cause = c.low_sync | c.manual_sync;
  endfunction

  // both causes come from the second stage only
  assign cause = '{low_sync: st_ff.low_meta[1], manual_sync: st_ff.manual_meta[1]};

  // timing of one cause, edges counted from the first sample:
  //   edge 0  pin captured in the first synchroniser stage
  //   edge 1  second stage shows the cause
  //   edge 2  phase drops to hold and the pin enable rises
  // so a cause reaches the pin after three edges, far inside the
  // latency budget; the third edge is the price of a clean
  // synchroniser on an asynchronous comparator.
  // release after the last cause clears:
  //   two edges to flush the synchronisers, one edge to enter the delay
  //   phase, then DELAY_CYCLES edges of counting before the pin lets go.
  // any cause seen during the count drops back to hold, so the full
  // delay always runs again from zero; toggling inputs can only
  // lengthen the wait, never shorten it.

  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // synchroniser stages shift on every live edge
    nxt_st.low_meta = {st_ff.low_meta[0], BELOW_LOWER};
    nxt_st.manual_meta = {st_ff.manual_meta[0], MANUAL_REQ};
    case (st_ff.phase)
      ssup_pkg::SSUP_HOLD: begin
        // stay low until supply is above upper and manual gone;
        // the upper comparator alone gives the hysteresis, so a supply
        // hovering between the two levels keeps the system in reset
        nxt_st.reset_out_n = 1'b0;
        nxt_st.count = `SSUP_CNT_RST;
        if (!hold_cause(cause) && ABOVE_UPPER) begin
          nxt_st.phase = ssup_pkg::SSUP_DELAY;
        end
      end
      ssup_pkg::SSUP_DELAY: begin
        // count cycles; any cause restarts the wait from zero
        nxt_st.reset_out_n = 1'b0;
        if (hold_cause(cause)) begin
          nxt_st.phase = ssup_pkg::SSUP_HOLD;
          nxt_st.count = `SSUP_CNT_RST;
        end else if (st_ff.count == DELAY_CYCLES[`SSUP_CNT_W-1:0] - `SSUP_CNT_ONE) begin
          // last count: the pin is let go on this edge
          nxt_st.phase = ssup_pkg::SSUP_RUN;
          nxt_st.reset_out_n = 1'b1;
          // count is left at its end value and cleared by the next cause
        end else begin
          // still counting; a dip of the upper level alone does not stop it
          nxt_st.count = st_ff.count + `SSUP_CNT_ONE;
        end
      end
      ssup_pkg::SSUP_RUN: begin
        // released; a cause pulls the pin straight down
        if (hold_cause(cause)) begin
          nxt_st.phase = ssup_pkg::SSUP_HOLD;
          nxt_st.reset_out_n = 1'b0;
          // clear the stale end count so the next wait starts from zero
          nxt_st.count = `SSUP_CNT_RST;
        end
      end
      default: begin
        // unused code: fall back to the safe, asserted phase
        nxt_st.phase = ssup_pkg::SSUP_HOLD;
        nxt_st.reset_out_n = 1'b0;
      end
    endcase
  end

  // state register; reset asserts the output from power-up.
  // reset is honoured even with the clock enable low, so a stalled
  // clock enable can never hold the system out of reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_ff.low_meta <= `SSUP_SYNC_RST;
      st_ff.manual_meta <= `SSUP_SYNC_RST;
      st_ff.phase <= ssup_pkg::SSUP_HOLD;
      st_ff.count <= `SSUP_CNT_RST;
      st_ff.reset_out_n <= 1'b0;
    end else if (CE) begin
      st_ff <= nxt_st;
    end
  end

  // open drain: only ever pulls low, enable is the inverse of the level.
  // the enable is registered from the next state, not the current one,
  // so pin and state change on the same edge; the data stays low so
  // the pin can never source current into the host, even on a glitch
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RESET_OUT_N_O <= 1'b0;
      RESET_OUT_N_OE <= 1'b1;
    end else if (CE) begin
      RESET_OUT_N_O <= 1'b0;
      RESET_OUT_N_OE <= ~nxt_st.reset_out_n;
    end
  end

  // helper for the tolerance checks only: cycles without a cause since
  // the controller last left hold; it saturates instead of wrapping so
  // a long quiet run never looks like a fresh short wait
  logic [`SSUP_CNT_W-1:0] low_run_ff; // cycles of continuous clean input
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      low_run_ff <= `SSUP_CNT_RST;
    end else if (CE) begin
      if (hold_cause(cause) || st_ff.phase == ssup_pkg::SSUP_HOLD) begin
        low_run_ff <= `SSUP_CNT_RST;
      end else if (low_run_ff != {`SSUP_CNT_W{1'b1}}) begin
        low_run_ff <= low_run_ff + `SSUP_CNT_ONE;
      end
    end
  end

  // named steps of a release
  sequence s_clean_wait;
    !hold_cause(cause) && st_ff.phase == ssup_pkg::SSUP_DELAY;
  endsequence
  sequence s_released;
    st_ff.reset_out_n;
  endsequence
  // named steps of a start: ready to count, and a quiet run
  sequence s_hold_ready;
    st_ff.phase == ssup_pkg::SSUP_HOLD && !hold_cause(cause) && ABOVE_UPPER;
  endsequence
  sequence s_quiet_run;
    st_ff.phase == ssup_pkg::SSUP_RUN && !hold_cause(cause);
  endsequence

  // assertions below sample the registered state one edge after the
  // cause is seen in the second synchroniser stage; those that watch the
  // pins expect the same edge, since state and pin share one register edge.
  // all but the reset check are silenced while reset is low

  a_under_asserts: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && st_ff.low_meta[1]) |=> !st_ff.reset_out_n)
    else $error("undervoltage did not assert reset");
  a_release_bound: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(st_ff.reset_out_n) |-> $past(st_ff.phase) == ssup_pkg::SSUP_DELAY)
    else $error("release without completed delay");
  a_delay_min: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(st_ff.reset_out_n) |-> low_run_ff >= MIN_CYCLES[`SSUP_CNT_W-1:0] - `SSUP_MIN_SLACK)
    else $error("release delay too short");
  a_delay_max: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (low_run_ff > MAX_CYCLES[`SSUP_CNT_W-1:0]) |-> st_ff.reset_out_n || !CE)
    else $error("release delay too long");
  a_manual_forces: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && st_ff.manual_meta[1]) |=> !st_ff.reset_out_n)
    else $error("manual request did not force reset");
  a_manual_start: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && $fell(st_ff.manual_meta[1]) && !st_ff.low_meta[1] && ABOVE_UPPER
     && st_ff.phase == ssup_pkg::SSUP_HOLD) |=> st_ff.phase == ssup_pkg::SSUP_DELAY)
    else $error("manual removal did not start delay");
  a_fast_assert: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE [*3] ##0 BELOW_LOWER [*3]) |=> RESET_OUT_N_OE)
    else $error("undervoltage latency too long");
  a_short_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && $rose(MANUAL_REQ)) ##1 (CE && MANUAL_REQ) [*2] |=> !st_ff.reset_out_n)
    else $error("manual pulse not detected");
  a_restart_wait: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && hold_cause(cause)) |=> st_ff.count == `SSUP_CNT_RST)
    else $error("delay not restarted by a cause");
  a_never_source: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_clean_wait |-> !RESET_OUT_N_O && RESET_OUT_N_OE)
    else $error("reset pin sourced or released early");
  a_release_drive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_released |-> !RESET_OUT_N_OE)
    else $error("pin pulled low while released");


  // reset pulls the pin low and keeps the data low whatever CE does
  a_reset_state: assert property (@(posedge CLK_SYS)
    !RST_N |=> RESET_OUT_N_OE && !RESET_OUT_N_O)
    else $error("reset did not assert the pin");
  // a frozen cycle changes no state and no pin
  a_ce_freeze: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !CE |=> st_ff == $past(st_ff) && $stable(RESET_OUT_N_OE))
    else $error("state moved while clock enable low");
  // hysteresis: hold is only left once the upper level is reached
  a_hold_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && st_ff.phase == ssup_pkg::SSUP_HOLD && !ABOVE_UPPER)
    |=> st_ff.phase == ssup_pkg::SSUP_HOLD)
    else $error("left hold below the upper level");
  // the delay starts from zero with the pin still held
  a_delay_start: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE ##0 s_hold_ready) |=> st_ff.phase == ssup_pkg::SSUP_DELAY
    && st_ff.count == `SSUP_CNT_RST && !st_ff.reset_out_n)
    else $error("upper level did not start the delay");

  // counter and phase consistency
  a_count_bound: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_ff.phase == ssup_pkg::SSUP_DELAY |-> st_ff.count < DELAY_CYCLES[`SSUP_CNT_W-1:0])
    else $error("delay counter ran past its end");
  a_hold_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    st_ff.phase == ssup_pkg::SSUP_HOLD |-> st_ff.count == `SSUP_CNT_RST)
    else $error("hold phase kept a stale count");
  a_run_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE ##0 s_quiet_run) |=> s_released)
    else $error("released pin dropped without a cause");
  a_manual_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && st_ff.manual_meta[1]) |=> st_ff.phase == ssup_pkg::SSUP_HOLD)
    else $error("manual request did not hold the controller");
  a_low_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && st_ff.low_meta[1]) |=> st_ff.phase == ssup_pkg::SSUP_HOLD)
    else $error("undervoltage did not hold the controller");
  a_latency_edge: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CE && $rose(st_ff.low_meta[1])) |=> RESET_OUT_N_OE)
    else $error("pin not pulled one edge after undervoltage");
  a_data_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !RESET_OUT_N_O)
    else $error("open-drain data not low");

  // the second synchroniser stage copies the first on every live edge
  a_sync_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    CE |=> st_ff.low_meta[1] == $past(st_ff.low_meta[0]))
    else $error("undervoltage synchroniser skipped a stage");
  a_sync_manual: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    CE |=> st_ff.manual_meta[1] == $past(st_ff.manual_meta[0]))
    else $error("manual synchroniser skipped a stage");

  // latency and pulse budgets must stay above the pipeline depth of three
  // edges, otherwise a slow clock would miss short manual pulses
  if (LATENCY_CYCLES < `SSUP_PIPE_MIN || MANUAL_CYCLES < `SSUP_PIPE_MIN) begin : g_slow_clock
    $error("clock too slow for latency budget");
  end
endmodule

// ===== tb/ssup_host.sv
/*
  host end of the reset line: pull-up and open-drain resolution.
  assumes the supervisor hands out data and enable as two pins.
*/
`timescale 1ns/100ps
module ssup_host (
  input wire logic CLK_SYS,
  input wire logic RESET_OUT_N_O,
  input wire logic RESET_OUT_N_OE,
  output wire logic RESET_LINE,
  output logic SOURCE_SEEN
);
  // released pin floats up through the pull-up; unknown enable stays unknown
  assign RESET_LINE = RESET_OUT_N_OE ? 1'b0 : 1'b1;
  initial SOURCE_SEEN = 1'b0;
  // sticky flag: an enabled driver must only ever pull low
  always @(posedge CLK_SYS) begin
    if (RESET_OUT_N_OE === 1'b1 && RESET_OUT_N_O !== 1'b0) begin
      SOURCE_SEEN <= 1'b1;
    end
  end
endmodule

// ===== tb/supply_reset_supervisor_bench.sv
/*
  self-checking bench for the supervisor core, random causes with seed.
  assumes the core, its package and the host model are compiled first.
*/
`timescale 1ns/100ps
module supply_reset_supervisor_bench;
  localparam int D = 50; // shortened delay keeps the run brief
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic below = 1'b0;
  logic above = 1'b0;
  // manual request idles low, as a grounded pin would
  logic manual = 1'b0;
  wire logic o, oe, line;
  logic src_seen;
  int fail_count = 0;
  int check_count = 0;
  int n, k, i;
  // free-running system clock, 50 ns
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  ssup_core #(.DELAY_CYCLES(D)) uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
    .BELOW_LOWER(below), .ABOVE_UPPER(above), .MANUAL_REQ(manual),
    .RESET_OUT_N_O(o), .RESET_OUT_N_OE(oe));
  ssup_host host (.CLK_SYS(clk_sys), .RESET_OUT_N_O(o), .RESET_OUT_N_OE(oe),
    .RESET_LINE(line), .SOURCE_SEEN(src_seen));
  task automatic check(logic seen, logic exp, string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // expected release span: the delay plus sync and register slack
  function automatic logic in_window(int c);
    return c >= D && c <= D + 8;
  endfunction
  // cause 0 is undervoltage, 1 is manual request
  task automatic cause(int c, logic on);
    @(posedge clk_sys);
    below <= on && c == 0;
    above <= !(on && c == 0);
    manual <= on && c == 1;
  endtask
  // falling-edge count until the line shows a level, bounded
  task automatic wait_line(logic lvl, int lim);
    n = 0;
    while (line !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    n = $urandom(38);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check(line, 1'b0, "line high in reset");
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2 * D) @(negedge clk_sys);
    check(line, 1'b0, "released below upper level");
    for (i = 0; i < 24; i++) begin
      // corners first, then random causes
      k = (i < 2) ? i : $urandom_range(1, 0);
      cause(0, 1'b0);
      wait_line(1'b1, D + 20);
      check(in_window(n), 1'b1, "release span");
      cause(k, 1'b1);
      wait_line(1'b0, 8);
      check(n <= 4, 1'b1, "slow assertion");
      repeat ((i == 1) ? 300 : $urandom_range(40, 1)) @(posedge clk_sys);
      // drop only the low cause, upper level absent: must stay held
      if (k == 0) begin
        @(posedge clk_sys);
        below <= 1'b0;
        repeat (3 * D) @(negedge clk_sys);
        check(line, 1'b0, "left reset without upper level");
      end
      cause(0, 1'b0);
      repeat ($urandom_range(D - 10, 3)) @(negedge clk_sys);
      check(line, 1'b0, "delay cut short");
      // a short cause inside the delay restarts it
      cause(k, 1'b1);
      repeat ($urandom_range(10, 3)) @(posedge clk_sys);
    end
    cause(0, 1'b0);
    wait_line(1'b1, D + 20);
    check(in_window(n), 1'b1, "delay not restarted");
    // freeze the clock enable mid-delay: the wait must stretch by the gap
    cause(1, 1'b1);
    repeat (4) @(posedge clk_sys);
    cause(0, 1'b0);
    repeat (10) @(posedge clk_sys);
    ce <= 1'b0;
    repeat (2 * D) @(negedge clk_sys);
    check(line, 1'b0, "released while frozen");
    @(posedge clk_sys);
    ce <= 1'b1;
    wait_line(1'b1, D + 20);
    check(n >= D - 8 && n <= D - 4, 1'b1, "frozen delay span");
    check(src_seen, 1'b0, "pin sourced current");
    wrap_up();
  end
endmodule
